// ==== rtl/kbdem_regs.sv ====
`include "kbdem_defs.svh"

// ----------------------------------------
// Host write buffer
// ----------------------------------------
module kbdem_fifo #(
  parameter int WIDTH = `KBDEM_FIFO_WIDTH,
  parameter int DEPTH = `KBDEM_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULLCNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic push;
  logic pop;

  // Handshakes use the registered flags only
  assign push = in_valid && in_ready;
  assign pop = out_ready && out_valid;
  assign out_data = mem[rd_ptr];

  // Occupancy; held flags keep ready free of logic
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + CW'(1);
    end else if (pop && !push) begin
      next_count = count - CW'(1);
    end
  end

  // Count and flags
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      count <= next_count;
      in_ready <= (next_count != FULLCNT);
      out_valid <= (next_count != '0);
    end
  end

  // Pointers wrap explicitly, so any depth works
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + PW'(1);
      end
    end
  end

  // Storage, no reset needed
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

// Contract
// - Registers decode at base offsets 0, 4, 8, 0xc and 0x14.
// - EC read at offset 0 returns last host byte, data or command; the code returns queued host bytes oldest first.
// - Status bits 7:6, 4 and 2 are plain EC read-write storage.
// - EC write of auxiliary output byte sets status bit 5.
// - EC write of normal output byte clears status bit 5.
// - Host command port write sets command/data bit 3.
// - Host data port write clears command/data bit 3.
// - Status bit 2 clears while LPC reset is asserted, and on main reset.
// - Host data or command byte sets input-full bit 1.
// - Input-full interrupt follows input-full bit when enabled.
// - EC read of input byte clears input-full and its interrupt.
// - Input-full and output-full ignore power-good and LPC power-down.
// - EC write of normal or auxiliary output byte sets output-full bit 0.
// - Host data read clears output-full and pulses output-full event.
// - EC status writes never change command/data, input-full, output-full.
module kbdem_regs #(
  parameter int FIFO_DEPTH = `KBDEM_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic lpc_reset_n,
  input wire logic power_good,
  input wire kbdem_pkg::kbdem_addr_t ec_addr,
  input wire logic ec_wr,
  input wire logic ec_rd,
  input wire kbdem_pkg::kbdem_byte_t ec_wdata,
  output kbdem_pkg::kbdem_byte_t ec_rdata,
  input wire logic host_wr,
  input wire logic host_wr_cmd,
  input wire kbdem_pkg::kbdem_byte_t host_wdata,
  output logic host_wr_ready,
  input wire logic host_rd_data,
  input wire logic host_rd_status,
  output kbdem_pkg::kbdem_byte_t host_rdata,
  input wire logic input_full_irq_en,
  output logic input_full_irq,
  output logic output_full_irq,
  output kbdem_pkg::kbdem_byte_t status,
  output kbdem_pkg::kbdem_byte_t kbd_control,
  output kbdem_pkg::kbdem_byte_t ctrl_output_flag
);
  import kbdem_pkg::*;

  // ----------------------------------------
  // Decode and internal state
  // ----------------------------------------
  kbdem_byte_t host_input_byte;
  kbdem_byte_t ec_output_byte;
  kbdem_byte_t ec_aux_output_byte;
  logic [1:0] user_bits_hi;
  logic user_bit_mid;
  logic user_bit_lpc_cleared;
  logic aux_output_full;
  logic cmd_data;
  logic input_full;
  logic output_full;
  logic next_input_full;
  logic fifo_valid;
  logic [8:0] fifo_data;
  logic load;
  logic wr_data;
  logic wr_status;
  logic wr_control;
  logic wr_aux;
  logic wr_flag;
  logic rd_data;

  // Address strobes, one per mapped offset
  assign wr_data = ec_wr && (ec_addr == `KBDEM_OFF_DATA);
  assign wr_status = ec_wr && (ec_addr == `KBDEM_OFF_STATUS);
  assign wr_control = ec_wr && (ec_addr == `KBDEM_OFF_CONTROL);
  assign wr_aux = ec_wr && (ec_addr == `KBDEM_OFF_AUX);
  assign wr_flag = ec_wr && (ec_addr == `KBDEM_OFF_FLAG);
  assign rd_data = ec_rd && (ec_addr == `KBDEM_OFF_DATA);

  // Host writes queue up; one byte held until the EC takes it
  kbdem_fifo #(
    .WIDTH(`KBDEM_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_host_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(host_wr),
    .in_ready(host_wr_ready),
    .in_data({host_wr_cmd, host_wdata}),
    .out_valid(fifo_valid),
    .out_ready(load),
    .out_data(fifo_data)
  );

  // A new byte lands only when the previous one was taken
  assign load = fifo_valid && !input_full;

  // ----------------------------------------
  // Input side
  // ----------------------------------------
  // Load sets, EC read clears; the set wins a tie
  always_comb begin
    next_input_full = input_full;
    if (load) begin
      next_input_full = 1'b1;
    end else if (rd_data) begin
      next_input_full = 1'b0;
    end
  end

  // Input byte and command/data flag; power-good not involved
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      host_input_byte <= `KBDEM_RST_BYTE;
      cmd_data <= 1'b0;
      input_full <= 1'b0;
    end else begin
      input_full <= next_input_full;
      if (load) begin
        host_input_byte <= fifo_data[7:0];
        cmd_data <= fifo_data[8];
      end
    end
  end

  // Registered request, so it drops with the read that clears the flag
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      input_full_irq <= 1'b0;
    end else begin
      input_full_irq <= next_input_full && input_full_irq_en;
    end
  end

  // ----------------------------------------
  // Output side
  // ----------------------------------------
  // Output bytes; offset 0 write leaves the input byte alone
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ec_output_byte <= `KBDEM_RST_BYTE;
      ec_aux_output_byte <= `KBDEM_RST_BYTE;
    end else begin
      if (wr_data) begin
        ec_output_byte <= ec_wdata;
      end
      if (wr_aux) begin
        ec_aux_output_byte <= ec_wdata;
      end
    end
  end

  // Output-full: EC write sets, host data read clears, set wins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      output_full <= 1'b0;
    end else if (wr_data || wr_aux) begin
      output_full <= 1'b1;
    end else if (host_rd_data) begin
      output_full <= 1'b0;
    end
  end

  // Event pulse, one cycle per host data read while output-full is set
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      output_full_irq <= 1'b0;
    end else begin
      output_full_irq <= host_rd_data && output_full;
    end
  end

  // Auxiliary flag, also writable through the status alias
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aux_output_full <= 1'b0;
    end else if (wr_aux) begin
      aux_output_full <= 1'b1;
    end else if (wr_data) begin
      aux_output_full <= 1'b0;
    end else if (wr_status) begin
      aux_output_full <= ec_wdata[`KBDEM_ST_AUX];
    end
  end

  // ----------------------------------------
  // User bits and plain storage
  // ----------------------------------------
  // Read-only flags are simply not in this write path
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      user_bits_hi <= 2'h0;
      user_bit_mid <= 1'b0;
    end else if (wr_status) begin
      user_bits_hi <= ec_wdata[`KBDEM_ST_UD2_HI:`KBDEM_ST_UD2_LO];
      user_bit_mid <= ec_wdata[`KBDEM_ST_UD1];
    end
  end

  // LPC reset outranks a same-cycle EC write
  always_ff @(posedge sys_clk) begin
    if (rst || !lpc_reset_n) begin
      user_bit_lpc_cleared <= 1'b0;
    end else if (wr_status) begin
      user_bit_lpc_cleared <= ec_wdata[`KBDEM_ST_UD0];
    end
  end

  // Control and flag registers held as plain bytes here
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      kbd_control <= `KBDEM_RST_CONTROL;
      ctrl_output_flag <= `KBDEM_RST_FLAG;
    end else begin
      if (wr_control) begin
        kbd_control <= ec_wdata;
      end
      if (wr_flag) begin
        ctrl_output_flag <= ec_wdata;
      end
    end
  end

  // ----------------------------------------
  // Read paths
  // ----------------------------------------
  kbdem_byte_t status_now;
  assign status_now = {user_bits_hi, aux_output_full, user_bit_mid, cmd_data,
                       user_bit_lpc_cleared, input_full, output_full};

  // Status mirrors flag registers one cycle late, from a flop
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status <= `KBDEM_RST_STATUS;
    end else begin
      status <= status_now;
    end
  end

  // EC read data; write-only and unmapped offsets read zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ec_rdata <= `KBDEM_RST_BYTE;
    end else if (ec_rd) begin
      case (ec_addr)
        `KBDEM_OFF_DATA: ec_rdata <= host_input_byte;
        `KBDEM_OFF_STATUS: ec_rdata <= status_now;
        `KBDEM_OFF_CONTROL: ec_rdata <= kbd_control;
        `KBDEM_OFF_FLAG: ec_rdata <= ctrl_output_flag;
        default: ec_rdata <= 8'h00;
      endcase
    end
  end

  // Host sees whichever output byte was written last
  kbdem_byte_t last_out;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      last_out <= `KBDEM_RST_BYTE;
    end else if (wr_data || wr_aux) begin
      last_out <= ec_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      host_rdata <= `KBDEM_RST_BYTE;
    end else if (host_rd_data) begin
      host_rdata <= last_out;
    end else if (host_rd_status) begin
      host_rdata <= status_now;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_ec_output_write;
    (wr_data || wr_aux);
  endsequence

  // Host data read while a byte is waiting, with no EC write racing it
  sequence s_host_take;
    host_rd_data && output_full && !wr_data && !wr_aux;
  endsequence

  a_ibf_on_load: assert property (@(posedge sys_clk) disable iff (rst)
    load |=> input_full && status[`KBDEM_ST_IBF] == 1'b0 ##1 status[`KBDEM_ST_IBF])
    else $error("input full not set after load");

  a_ibf_ec_read: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_data && !load) |=> !input_full && !input_full_irq)
    else $error("input full or irq not cleared by EC read");

  a_cd_follow: assert property (@(posedge sys_clk) disable iff (rst)
    load |=> cmd_data == $past(fifo_data[8]) && host_input_byte == $past(fifo_data[7:0]))
    else $error("command/data or input byte wrong after load");

  a_irq_gate: assert property (@(posedge sys_clk) disable iff (rst)
    input_full_irq |-> input_full && $past(input_full_irq_en))
    else $error("input irq without full or enable");

  a_obf_set: assert property (@(posedge sys_clk) disable iff (rst)
    s_ec_output_write |=> output_full ##1 status[`KBDEM_ST_OBF])
    else $error("output full not set by EC write");

  a_obf_take: assert property (@(posedge sys_clk) disable iff (rst)
    s_host_take |=> !output_full && output_full_irq ##1 !output_full_irq)
    else $error("host read did not clear output full or pulse event");

  a_aux_flag: assert property (@(posedge sys_clk) disable iff (rst)
    wr_aux |=> aux_output_full && output_full)
    else $error("aux flag not set");

  a_aux_clear: assert property (@(posedge sys_clk) disable iff (rst)
    wr_data |=> !aux_output_full && ec_output_byte == $past(ec_wdata))
    else $error("aux flag not cleared or output byte not stored");

  a_ud0_lpc: assert property (@(posedge sys_clk) disable iff (rst)
    !lpc_reset_n |=> !user_bit_lpc_cleared)
    else $error("user bit 2 survived LPC reset");

  a_ro_bits: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_status && !load && !rd_data && !host_rd_data) |=> $stable(cmd_data) && $stable(input_full)
      && $stable(output_full))
    else $error("read-only status bit changed by EC write");

  a_alias_read: assert property (@(posedge sys_clk) disable iff (rst)
    rd_data |=> ec_rdata == $past(host_input_byte))
    else $error("input alias read wrong");

  a_in_untouched: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_data && !load) |=> $stable(host_input_byte))
    else $error("EC write altered input byte");

  a_pg_ignored: assert property (@(posedge sys_clk) disable iff (rst)
    ($changed(power_good) && !load && !rd_data && !ec_wr && !host_rd_data) |=>
      $stable(input_full) && $stable(output_full))
    else $error("flags moved with power good");
endmodule

// ==== rtl/kbdem_defs.svh ====
`ifndef KBDEM_DEFS_SVH
`define KBDEM_DEFS_SVH

// ----------------------------------------
// Register offsets from the block base
// ----------------------------------------
`define KBDEM_OFF_DATA 5'h00
`define KBDEM_OFF_STATUS 5'h04
`define KBDEM_OFF_CONTROL 5'h08
`define KBDEM_OFF_AUX 5'h0c
`define KBDEM_OFF_FLAG 5'h14

// ----------------------------------------
// Status byte field positions
// ----------------------------------------
`define KBDEM_ST_OBF 0
`define KBDEM_ST_IBF 1
`define KBDEM_ST_UD0 2
`define KBDEM_ST_CD 3
`define KBDEM_ST_UD1 4
`define KBDEM_ST_AUX 5
`define KBDEM_ST_UD2_LO 6
`define KBDEM_ST_UD2_HI 7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define KBDEM_RST_BYTE 8'h00
`define KBDEM_RST_STATUS 8'h00
`define KBDEM_RST_CONTROL 8'h00
`define KBDEM_RST_FLAG 8'h00

// ----------------------------------------
// Buffer sizing
// ----------------------------------------
`define KBDEM_FIFO_DEPTH 16
`define KBDEM_FIFO_WIDTH 9

`endif

// ==== rtl/kbdem_pkg.sv ====
package kbdem_pkg;
  // ----------------------------------------
  // Shared types
  // ----------------------------------------
  typedef logic [4:0] kbdem_addr_t;
  typedef logic [7:0] kbdem_byte_t;
endpackage

// ==== verif/kbdem_host_model.sv ====
// Host side of the emulated keyboard controller: issues port writes and reads
module kbdem_host_model (
  input wire logic sys_clk,
  output logic host_wr,
  output logic host_wr_cmd,
  output kbdem_pkg::kbdem_byte_t host_wdata,
  input wire logic host_wr_ready,
  output logic host_rd_data,
  output logic host_rd_status,
  input wire kbdem_pkg::kbdem_byte_t host_rdata,
  input wire logic output_full_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  import kbdem_pkg::*;

  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  initial begin
    host_wr = 1'b0;
    host_wr_cmd = 1'b0;
    host_wdata = 8'h00;
    host_rd_data = 1'b0;
    host_rd_status = 1'b0;
  end

  // ----------------------------------------
  // Port write, held until ready is seen high
  // ----------------------------------------
  // With wait_ready low the request is offered for one edge only,
  // so a refusal can be provoked on purpose
  task automatic send(input logic cmd, input kbdem_byte_t b, input logic wait_ready, output logic ok);
    int n;
    n = 0;
    @(posedge sys_clk);
    #1;
    host_wr = 1'b1;
    host_wr_cmd = cmd;
    host_wdata = b;
    while (wait_ready && host_wr_ready !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    ok = (host_wr_ready === 1'b1);
    @(posedge sys_clk);
    #1;
    host_wr = 1'b0;
    host_wr_cmd = ~cmd; // Released lines show garbage, not the old value
    host_wdata = ~b;
  endtask

  // ----------------------------------------
  // Port read: data port or status port
  // ----------------------------------------
  task automatic fetch(input logic data_port, output kbdem_byte_t b, output logic evt);
    @(posedge sys_clk);
    #1;
    host_rd_data = data_port;
    host_rd_status = !data_port;
    @(posedge sys_clk);
    #1;
    host_rd_data = 1'b0;
    host_rd_status = 1'b0;
    b = host_rdata;
    evt = output_full_irq; // Event pulse stands only in this cycle
  endtask
endmodule

// ==== verif/kbd_ctrl_emulation_ec_regs_tb_top.sv ====
`include "kbdem_defs.svh"

module kbd_ctrl_emulation_ec_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import kbdem_pkg::*;

  logic sys_clk, rst, lpc_reset_n, power_good, ec_wr, ec_rd, input_full_irq_en;
  logic host_wr, host_wr_cmd, host_wr_ready, host_rd_data, host_rd_status;
  logic input_full_irq, output_full_irq, e, ok;
  kbdem_addr_t ec_addr;
  kbdem_byte_t ec_wdata, ec_rdata, host_wdata, host_rdata, status, kbd_control, ctrl_output_flag, b;
  int fails, check_count;

  // ----------------------------------------
  // Device and host partner
  // ----------------------------------------
  // Small buffer depth so a refusal is reached in a few writes
  kbdem_regs #(.FIFO_DEPTH(2)) kbdem_regs_inst (.sys_clk(sys_clk), .rst(rst), .lpc_reset_n(lpc_reset_n),
    .power_good(power_good), .ec_addr(ec_addr), .ec_wr(ec_wr), .ec_rd(ec_rd), .ec_wdata(ec_wdata),
    .ec_rdata(ec_rdata), .host_wr(host_wr), .host_wr_cmd(host_wr_cmd), .host_wdata(host_wdata),
    .host_wr_ready(host_wr_ready), .host_rd_data(host_rd_data), .host_rd_status(host_rd_status),
    .host_rdata(host_rdata), .input_full_irq_en(input_full_irq_en), .input_full_irq(input_full_irq),
    .output_full_irq(output_full_irq), .status(status), .kbd_control(kbd_control),
    .ctrl_output_flag(ctrl_output_flag));
  kbdem_host_model kbdem_host_model_inst (.sys_clk(sys_clk), .host_wr(host_wr), .host_wr_cmd(host_wr_cmd),
    .host_wdata(host_wdata), .host_wr_ready(host_wr_ready), .host_rd_data(host_rd_data),
    .host_rd_status(host_rd_status), .host_rdata(host_rdata), .output_full_irq(output_full_irq));

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Compare, bus tasks, report
  // ----------------------------------------
  task automatic chk(input string nm, input kbdem_byte_t ex, input kbdem_byte_t got);
    check_count++;
    if (got !== ex) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic ec_w(input kbdem_addr_t a, input kbdem_byte_t d);
    @(posedge sys_clk);
    #1;
    ec_wr = 1'b1;
    ec_addr = a;
    ec_wdata = d;
    @(posedge sys_clk);
    #1;
    ec_wr = 1'b0;
    ec_addr = ~a;
    ec_wdata = ~d;
  endtask
  task automatic ec_r(input kbdem_addr_t a, input kbdem_byte_t ex, input string nm);
    @(posedge sys_clk);
    #1;
    ec_rd = 1'b1;
    ec_addr = a;
    @(posedge sys_clk);
    #1;
    ec_rd = 1'b0;
    chk(nm, ex, ec_rdata);
  endtask
  // Status via the bus, then the status port once it has caught up
  task automatic st(input kbdem_byte_t ex);
    ec_r(`KBDEM_OFF_STATUS, ex, "status_read");
    repeat (2) @(posedge sys_clk);
    #1;
    chk("status_port", ex, status);
  endtask
  // Load lands one edge after the take, status one edge later; three leaves margin
  task automatic hw(input logic cmd, input kbdem_byte_t d);
    kbdem_host_model_inst.send(cmd, d, 1'b1, ok);
    chk("host_accepted", 8'h01, {7'h00, ok});
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    fails = 0;
    check_count = 0;
    rst = 1'b1;
    lpc_reset_n = 1'b1;
    power_good = 1'b1;
    ec_wr = 1'b0;
    ec_rd = 1'b0;
    ec_addr = 5'h00;
    ec_wdata = 8'h00;
    input_full_irq_en = 1'b1;
    repeat (16) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    chk("wr_ready", 8'h01, {7'h00, host_wr_ready});
    ec_r(`KBDEM_OFF_DATA, 8'h00, "data_rst");
    ec_r(`KBDEM_OFF_CONTROL, 8'h00, "ctrl_rst");
    ec_r(`KBDEM_OFF_AUX, 8'h00, "aux_rd");
    ec_r(`KBDEM_OFF_FLAG, 8'h00, "flag_rst");
    st(8'h00);
    ec_w(`KBDEM_OFF_CONTROL, 8'h5a);
    ec_w(`KBDEM_OFF_FLAG, 8'hc3);
    ec_w(5'h10, 8'hff);
    ec_r(`KBDEM_OFF_CONTROL, 8'h5a, "ctrl");
    ec_r(`KBDEM_OFF_FLAG, 8'hc3, "flag");
    ec_r(5'h10, 8'h00, "unmapped");
    chk("ctrl_port", 8'h5a, kbd_control);
    chk("flag_port", 8'hc3, ctrl_output_flag);
    // Command byte, then data byte with the interrupt masked
    hw(1'b1, 8'ha5);
    st(8'h0a);
    chk("ibf_irq", 8'h01, {7'h00, input_full_irq});
    ec_r(`KBDEM_OFF_DATA, 8'ha5, "cmd_byte");
    chk("ibf_irq_clr", 8'h00, {7'h00, input_full_irq});
    st(8'h08);
    input_full_irq_en = 1'b0;
    hw(1'b0, 8'h3c);
    st(8'h02);
    chk("irq_masked", 8'h00, {7'h00, input_full_irq});
    ec_r(`KBDEM_OFF_DATA, 8'h3c, "data_byte");
    // Output byte must not overwrite the input alias
    ec_w(`KBDEM_OFF_DATA, 8'h77);
    ec_r(`KBDEM_OFF_DATA, 8'h3c, "alias_kept");
    st(8'h01);
    kbdem_host_model_inst.fetch(1'b1, b, e);
    chk("host_data", 8'h77, b);
    chk("obf_event", 8'h01, {7'h00, e});
    st(8'h00);
    kbdem_host_model_inst.fetch(1'b1, b, e);
    chk("no_event", 8'h00, {7'h00, e});
    ec_w(`KBDEM_OFF_AUX, 8'h55);
    st(8'h21);
    kbdem_host_model_inst.fetch(1'b0, b, e);
    chk("host_status", 8'h21, b);
    kbdem_host_model_inst.fetch(1'b1, b, e);
    chk("aux_data", 8'h55, b);
    ec_w(`KBDEM_OFF_DATA, 8'h66);
    st(8'h01);
    // Status writes touch only the user and aux bits
    ec_w(`KBDEM_OFF_STATUS, 8'hff);
    st(8'hf5);
    ec_w(`KBDEM_OFF_STATUS, 8'h00);
    st(8'h01);
    hw(1'b1, 8'h11);
    ec_w(`KBDEM_OFF_STATUS, 8'h00);
    st(8'h0b);
    ec_r(`KBDEM_OFF_DATA, 8'h11, "cmd2");
    hw(1'b0, 8'h22);
    ec_w(`KBDEM_OFF_STATUS, 8'h14);
    st(8'h17);
    // LPC reset and power-good drop hit only user bit 2
    @(posedge sys_clk);
    #1;
    lpc_reset_n = 1'b0;
    power_good = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    lpc_reset_n = 1'b1;
    st(8'h13);
    power_good = 1'b1;
    st(8'h13);
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    st(8'h00);
    // Fill the buffer until refused while the EC stalls, then drain
    for (int i = 0; i < 3; i++) begin
      kbdem_host_model_inst.send(i[0], 8'h40 + 8'(i), 1'b1, ok);
      chk("accepted", 8'h01, {7'h00, ok});
    end
    repeat (3) @(posedge sys_clk);
    #1;
    chk("full", 8'h00, {7'h00, host_wr_ready});
    // Offered for one edge only while full: must be turned away
    kbdem_host_model_inst.send(1'b1, 8'h4f, 1'b0, ok);
    chk("refused", 8'h00, {7'h00, ok});
    for (int i = 0; i < 3; i++) begin
      ec_r(`KBDEM_OFF_DATA, 8'h40 + 8'(i), "fifo_order");
      repeat (3) @(posedge sys_clk);
    end
    st(8'h00);
    chk("drained", 8'h01, {7'h00, host_wr_ready});
    tally_and_finish();
  end
endmodule
